// ==== rtl/hip_top.sv ====
// parallel host port, strap capture and serial gating for the line interface device
// assumes: strobes/pins are asynchronous and synchronised here; register file outside
// Operation
// - straps sampled each reset; 00 separate strobes, 01 data strobe parallel
// - strap 11 selects serial control link, always slave
// - strap 10 selects spi, always slave
// - strap mode valid right after reset release, no software step
// - serial link mode takes source address bits 5:0 from address straps
// - serial modes take multiplier m from d15:11 and n from d10:5
// - register address space is eleven bits wide
// - parallel modes drive transfer acknowledge marking each access end
// - separate-strobe read: ready low once data stable, held after strobe rise
// - separate-strobe write: ready low after strobe fall, high after write done
// - bus width selectable 8 or 16 bits in both conventions
// - separate-strobe lane steering by high enable and address bit 0
// - data-strobe lane steering by low enable and address bit 0
// - word at even n: address n low lanes sep-strobe, high lanes data-strobe
// - constant latch strobe demultiplexed; toggling under 00 latches multiplexed address
// - byte and word accesses interleave freely
// - serial control link is three-wire framed message slave
// - serial access refused until multiplier locks; no ack, spi output tristate
`timescale 1ns/1ps
module hip_top
  import hip_pkg::*;
(
  input  wire logic                              core_clk,
  input  wire logic                              nrst,
  input  wire logic [1:0]                        host_mode_straps,
  input  wire logic                              bus_width_16,
  input  wire logic                              cs_n,
  input  wire logic                              rd_n,
  input  wire logic                              wr_n,
  input  wire logic                              ale,
  input  wire logic                              high_byte_enable_n,
  input  wire logic                              low_lane_enable_n,
  input  wire logic [hip_pkg::ADDR_W-1:0]        addr_in,
  input  wire logic [hip_pkg::DATA_W-1:0]        data_in,
  output logic      [hip_pkg::DATA_W-1:0]        data_out,
  output logic      [1:0]                        data_oe,
  output logic                                   transfer_ack_n,
  output logic                                   transfer_ack_oe,
  output logic      [hip_pkg::ADDR_W-1:0]        reg_addr,
  output logic                                   reg_rd,
  output logic                                   reg_wr,
  output logic      [hip_pkg::DATA_W-1:0]        reg_wdata,
  output logic      [1:0]                        reg_lane_en,
  input  wire logic [hip_pkg::DATA_W-1:0]        reg_rdata,
  input  wire logic                              reg_done,
  input  wire logic                              pll_locked,
  output logic      [1:0]                        host_mode,
  output logic                                   serial_link_en,
  output logic                                   spi_en,
  output logic      [hip_pkg::SRC_ADDR_W-1:0]    link_src_addr,
  output logic      [hip_pkg::MULT_M_W-1:0]      clock_mult_cfg_a,
  output logic      [hip_pkg::MULT_N_W-1:0]      clock_mult_cfg_b,
  output logic                                   strap_mult_valid,
  output logic                                   serial_access_ok,
  output logic                                   serial_data_out_oe_allow
);
  import hip_pkg::*;

  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) rst_sync_q <= 2'h0;
    else       rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // two-flop synchronisers for all pin inputs; stage one is read only by stage two
  localparam int unsigned SW = 2 + 1 + 6 + ADDR_W + DATA_W + 1;
  logic [SW-1:0] pin_raw, s1_q, s2_q;
  assign pin_raw = {host_mode_straps, bus_width_16, cs_n, rd_n, wr_n, ale,
                    high_byte_enable_n, low_lane_enable_n, addr_in, data_in, pll_locked};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end
  logic [1:0]        st_mode;
  logic              s_w16, s_cs_n, s_rd_n, s_wr_n, s_ale, s_bhe_n, s_ble_n, s_lock;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_data;
  assign {st_mode, s_w16, s_cs_n, s_rd_n, s_wr_n, s_ale, s_bhe_n, s_ble_n,
          s_addr, s_data, s_lock} = s2_q;

  // strap capture: once, two synchroniser cycles after every reset release
  logic                  cap_done_q, cap_done_d;
  logic [1:0]            mode_q, mode_d;
  logic [SRC_ADDR_W-1:0] src_q, src_d;
  logic [MULT_M_W-1:0]   m_q, m_d;
  logic [MULT_N_W-1:0]   n_q, n_d;
  logic [1:0]            warm_q, warm_d;
  always_comb begin
    cap_done_d = cap_done_q;
    mode_d     = mode_q;
    src_d      = src_q;
    m_d        = m_q;
    n_d        = n_q;
    warm_d     = warm_q;
    if (warm_q != 2'h2) warm_d = warm_q + 2'h1;
    else if (!cap_done_q) begin
      cap_done_d = 1'b1;
      mode_d     = st_mode;
      src_d      = s_addr[SRC_ADDR_W-1:0];
      m_d        = s_data[M_HI:M_LO];
      n_d        = s_data[N_HI:N_LO];
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_done_q <= 1'b0;
      mode_q     <= MODE_SEP_STROBE;
      src_q      <= '0;
      m_q        <= '0;
      n_q        <= '0;
      warm_q     <= 2'h0;
    end else begin
      cap_done_q <= cap_done_d;
      mode_q     <= mode_d;
      src_q      <= src_d;
      m_q        <= m_d;
      n_q        <= n_d;
      warm_q     <= warm_d;
    end
  end

  logic is_par, is_sep;
  assign is_par           = cap_done_q && !mode_q[1];
  assign is_sep           = mode_q == MODE_SEP_STROBE;
  assign host_mode        = mode_q;
  assign serial_link_en   = cap_done_q && mode_q == MODE_LINK;
  assign spi_en           = cap_done_q && mode_q == MODE_SPI;
  assign link_src_addr    = serial_link_en ? src_q : '0;
  assign strap_mult_valid = cap_done_q && mode_q[1];
  assign clock_mult_cfg_a = strap_mult_valid ? m_q : '0;
  assign clock_mult_cfg_b = strap_mult_valid ? n_q : '0;
  // no serial access, no ack and no spi drive before lock
  assign serial_access_ok         = mode_q[1] && cap_done_q && s_lock;
  assign serial_data_out_oe_allow = spi_en && s_lock;

  // lane decode shared by both conventions, returns {hi_lane, lo_lane}
  function automatic logic [1:0] lane_sel(input logic sep, input logic w16,
                                          input logic en_n, input logic a0);
    if (!w16)           lane_sel = 2'b01;
    else if (en_n & a0) lane_sel = 2'b00;
    else if (!en_n & !a0) lane_sel = 2'b11;
    else if (sep)       lane_sel = a0 ? 2'b10 : 2'b01;
    else                lane_sel = a0 ? 2'b01 : 2'b10;
  endfunction

  // multiplexed address latch on ale fall, only under separate strobes
  logic              ale_d1_q;
  logic [ADDR_W-1:0] lat_addr_q, lat_addr_d;
  logic              muxed_q, muxed_d;
  always_comb begin
    lat_addr_d = lat_addr_q;
    muxed_d    = muxed_q;
    if (is_sep && ale_d1_q && !s_ale) begin
      // the address rides on the data pins while ale pulses
      lat_addr_d = s_data[ADDR_W-1:0];
      muxed_d    = 1'b1;
    end
  end

  hip_state_t        st_q, st_d;
  logic [2:0]        hold_q, hold_d;
  logic              wr_cyc_q, wr_cyc_d;
  logic [1:0]        lanes_q, lanes_d;
  logic [ADDR_W-1:0] ra_q, ra_d;
  logic [DATA_W-1:0] rdat_q, rdat_d;
  logic              ack_q, ack_d;
  logic              rd_q, rd_d, wr_q, wr_d;
  logic [DATA_W-1:0] wd_q, wd_d;
  logic              swap_q, swap_d;
  logic              strobe_rd, strobe_wr, ds_n, en_n;
  logic [ADDR_W-1:0] acc_addr;
  // data strobe convention: rd_n is the strobe, wr_n carries read-not-write
  assign ds_n      = s_rd_n;
  assign strobe_rd = is_sep ? !s_rd_n : (!ds_n && s_wr_n);
  assign strobe_wr = is_sep ? !s_wr_n : (!ds_n && !s_wr_n);
  assign en_n      = is_sep ? s_bhe_n : s_ble_n;
  assign acc_addr  = muxed_q ? lat_addr_q : s_addr;

  always_comb begin
    st_d     = st_q;
    hold_d   = hold_q;
    wr_cyc_d = wr_cyc_q;
    lanes_d  = lanes_q;
    ra_d     = ra_q;
    rdat_d   = rdat_q;
    ack_d    = 1'b0;
    rd_d     = 1'b0;
    wr_d     = 1'b0;
    wd_d     = wd_q;
    swap_d   = swap_q;
    unique case (st_q)
      HIP_IDLE: begin
        if (is_par && !s_cs_n && (strobe_rd || strobe_wr)) begin
          lanes_d  = lane_sel(is_sep, s_w16, en_n, acc_addr[0]);
          ra_d     = {acc_addr[ADDR_W-1:1], acc_addr[0] & ~s_w16};
          wr_cyc_d = strobe_wr;
          wd_d     = s_data;
          swap_d   = s_w16 ? !is_sep : acc_addr[0];
          st_d     = HIP_ACCESS;
        end
      end
      HIP_ACCESS: begin
        if (lanes_q == 2'b00) begin
          ack_d = 1'b1;                           // no transfer, still finish handshake
          st_d  = HIP_WAIT_END;
        end else if (wr_cyc_q) begin
          ack_d = 1'b1;
          // the write lands only once the strobe is gone, so ack can span it
          if (!strobe_wr) begin
            wr_d = 1'b1;
            st_d = HIP_WAIT_END;
          end
        end else begin
          rd_d = 1'b1;
          if (reg_done) begin
            rdat_d = reg_rdata;
            st_d   = HIP_WAIT_END;
          end
        end
      end
      HIP_WAIT_END: begin
        // read: ack once data is registered; write: ack stays on until the write completed, then drops
        ack_d = wr_cyc_q ? !reg_done && lanes_q != 2'b00 : 1'b1;
        if (wr_cyc_q && (reg_done || lanes_q == 2'b00)) ack_d = 1'b0;
        if (!wr_cyc_q || lanes_q == 2'b00) ack_d = 1'b1;
        if (!strobe_rd && !strobe_wr && (!wr_cyc_q || !ack_q || lanes_q == 2'b00)) begin
          hold_d = RDY_HOLD_INIT;
          st_d   = HIP_HOLD;
        end
      end
      HIP_HOLD: begin
        ack_d = !wr_cyc_q;
        if (hold_q <= 3'h1) begin
          ack_d = 1'b0;
          st_d  = HIP_IDLE;
        end else hold_d = hold_q - 3'h1;
      end
      default: st_d = HIP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ale_d1_q   <= 1'b0;
      lat_addr_q <= '0;
      muxed_q    <= 1'b0;
      st_q       <= HIP_IDLE;
      hold_q     <= 3'h0;
      wr_cyc_q   <= 1'b0;
      lanes_q    <= 2'h0;
      ra_q       <= '0;
      rdat_q     <= '0;
      ack_q      <= 1'b0;
      rd_q       <= 1'b0;
      wr_q       <= 1'b0;
      wd_q       <= '0;
      swap_q     <= 1'b0;
    end else begin
      ale_d1_q   <= s_ale;
      lat_addr_q <= lat_addr_d;
      muxed_q    <= muxed_d;
      st_q       <= st_d;
      hold_q     <= hold_d;
      wr_cyc_q   <= wr_cyc_d;
      lanes_q    <= lanes_d;
      ra_q       <= ra_d;
      rdat_q     <= rdat_d;
      ack_q      <= ack_d;
      rd_q       <= rd_d;
      wr_q       <= wr_d;
      wd_q       <= wd_d;
      swap_q     <= swap_d;
    end
  end

  // word at even n: n on low lanes for separate strobes, high lanes for data strobe
  assign reg_addr    = ra_q;
  assign reg_rd      = rd_q;
  assign reg_wr      = wr_q;
  // register side keeps the even byte on lane 0; odd bytes on an 8-bit bus swap too
  assign reg_lane_en = swap_q ? {lanes_q[0], lanes_q[1]} : lanes_q;
  assign reg_wdata   = swap_q ? {wd_q[7:0], wd_q[15:8]} : wd_q;
  assign data_out    = swap_q ? {rdat_q[7:0], rdat_q[15:8]} : rdat_q;
  // bus released whenever no read cycle is running
  assign data_oe     = (!wr_cyc_q && st_q != HIP_IDLE && st_q != HIP_ACCESS &&
                        !s_cs_n) ? lanes_q : 2'b00;
  // ready is low-active when acknowledging; drive only in parallel modes
  assign transfer_ack_n  = !ack_q;
  assign transfer_ack_oe = is_par;

  ack_release_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == HIP_IDLE) |=> !ack_q || st_q != HIP_IDLE)
    else $error("acknowledge active while idle");
  serial_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !s_lock |-> !serial_data_out_oe_allow && !serial_access_ok)
    else $error("serial access before lock");
  mode_stable_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cap_done_q |=> cap_done_q && $stable(mode_q))
    else $error("strap mode changed without reset");
  cap_time_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> ##3 cap_done_q)
    else $error("strap capture late");
  par_only_ack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ack_q |-> is_par)
    else $error("acknowledge outside parallel mode");
  no_xfer_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (lanes_q == 2'b00) |-> !reg_rd && !reg_wr)
    else $error("transfer with no lanes");
  mult_src_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !strap_mult_valid |-> clock_mult_cfg_a == '0 && clock_mult_cfg_b == '0)
    else $error("strap multiplier used in parallel mode");
  src_addr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !serial_link_en |-> link_src_addr == '0)
    else $error("source address outside link mode");
endmodule // hip_top

// ==== shared/hip_pkg.sv ====
// package for the host interface select and parallel port block
// assumes a single 200 MHz core clock domain
package hip_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned RDY_HOLD_PS     = 10000;
  localparam int unsigned RDY_HOLD_CYC    = (RDY_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ADDR_W          = 11;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned SRC_ADDR_W      = 6;
  localparam int unsigned MULT_M_W        = 5;
  localparam int unsigned MULT_N_W        = 6;
  localparam int unsigned M_HI            = 15;
  localparam int unsigned M_LO            = 11;
  localparam int unsigned N_HI            = 10;
  localparam int unsigned N_LO            = 5;
  localparam logic [1:0]  MODE_SEP_STROBE = 2'h0;
  localparam logic [1:0]  MODE_DATA_STROBE = 2'h1;
  localparam logic [1:0]  MODE_SPI        = 2'h2;
  localparam logic [1:0]  MODE_LINK       = 2'h3;
  localparam logic [2:0]  RDY_HOLD_INIT   = 3'(RDY_HOLD_CYC);
  typedef enum logic [2:0] {HIP_IDLE, HIP_ACCESS, HIP_HOLD, HIP_WAIT_END} hip_state_t;
endpackage

// ==== tb/hip_regfile_model.sv ====
// register file stand-in behind the parallel port, answering after a settable wait
// assumes one clock; lane 0 of a word holds the even byte address
`timescale 1ns/1ps
module hip_regfile_model
  import hip_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic [hip_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                       reg_rd,
  input  wire logic                       reg_wr,
  input  wire logic [hip_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic [1:0]                 reg_lane_en,
  input  wire logic [3:0]                 wait_cyc,
  output logic      [hip_pkg::DATA_W-1:0] reg_rdata,
  output logic                            reg_done
);
  logic [15:0] mem [0:1023];
  logic [3:0]  cnt_q;
  logic        busy_q;
  logic        served_q;
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 16'h0;
    reg_done = 1'b0;
    reg_rdata = 16'h0;
    busy_q = 1'b0;
    served_q = 1'b0;
    cnt_q = 4'h0;
  end
  // read bus churns outside an answer so a stale value never passes as valid
  always @(posedge core_clk) begin
    reg_done <= 1'b0;
    reg_rdata <= ~reg_rdata;
    if (busy_q) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h0) begin
        reg_done <= 1'b1;
        busy_q <= 1'b0;
        served_q <= 1'b1;
        reg_rdata <= mem[reg_addr[10:1]];
      end
    end else if ((reg_rd || reg_wr) && !served_q) begin
      busy_q <= 1'b1;
      cnt_q <= wait_cyc;
      if (reg_wr && reg_lane_en[0]) mem[reg_addr[10:1]][7:0] <= reg_wdata[7:0];
      if (reg_wr && reg_lane_en[1]) mem[reg_addr[10:1]][15:8] <= reg_wdata[15:8];
    end else if (!reg_rd) begin
      served_q <= 1'b0;
    end
  end
endmodule // hip_regfile_model

// ==== tb/test_hip_top.sv ====
// testbench: strap capture, serial gating and both parallel strobe conventions
// assumes hip_top as declared and the register file stand-in beside it
`timescale 1ns/1ps
module test_hip_top;
  import hip_pkg::*;
  logic        core_clk = 1'b0, nrst, bus_width_16, cs_n, rd_n, wr_n, ale;
  logic        high_byte_enable_n, low_lane_enable_n, pll_locked, reg_rd, reg_wr, reg_done;
  logic [1:0]  host_mode_straps, data_oe, reg_lane_en, host_mode;
  logic [10:0] addr_in, reg_addr;
  logic [15:0] data_in, data_out, reg_wdata, reg_rdata;
  logic        transfer_ack_n, transfer_ack_oe, serial_link_en, spi_en, strap_mult_valid;
  logic        serial_access_ok, serial_data_out_oe_allow;
  logic [5:0]  link_src_addr;
  logic [4:0]  clock_mult_cfg_a;
  logic [5:0]  clock_mult_cfg_b;
  logic [3:0]  wait_cyc;
  int          fail_count = 0, total_checks = 0, cyc = 0, polls = 0;

  hip_top u_hip_top (.core_clk, .nrst, .host_mode_straps, .bus_width_16, .cs_n, .rd_n,
    .wr_n, .ale, .high_byte_enable_n, .low_lane_enable_n, .addr_in, .data_in, .data_out,
    .data_oe, .transfer_ack_n, .transfer_ack_oe, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_lane_en, .reg_rdata, .reg_done, .pll_locked, .host_mode, .serial_link_en, .spi_en,
    .link_src_addr, .clock_mult_cfg_a, .clock_mult_cfg_b, .strap_mult_valid,
    .serial_access_ok, .serial_data_out_oe_allow);
  hip_regfile_model u_hip_regfile_model (.core_clk, .reg_addr, .reg_rd, .reg_wr,
    .reg_wdata, .reg_lane_en, .wait_cyc, .reg_rdata, .reg_done);

  always #2.5 core_clk = ~core_clk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // a hang counts as a mismatch and still ends in the closing report
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // straps are only trusted across a full reset
  task automatic do_reset(input logic [1:0] m, input logic [15:0] d, input logic [10:0] a);
    @(negedge core_clk);
    nrst = 1'b0;
    pll_locked = 1'b0;
    host_mode_straps = m;
    data_in = d;
    addr_in = a;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    repeat (10) @(negedge core_clk);
    data_in = ~d;
    addr_in = ~a;
  endtask

  task automatic acc(input bit ds, input bit wr, input bit mux, input logic [10:0] a,
                     input logic en_n, input logic [15:0] wd, input logic [15:0] exp,
                     input logic [1:0] oe);
    int n;
    @(negedge core_clk);
    cs_n = 1'b0;
    addr_in = mux ? ~a : a;
    data_in = mux ? {wd[15:11], a} : wd;
    high_byte_enable_n = ds ? 1'b1 : en_n;
    low_lane_enable_n = ds ? en_n : 1'b1;
    if (mux) begin
      // address only on the data pins during the ale pulse; address pins carry junk
      ale = 1'b1;
      @(negedge core_clk);
      ale = 1'b0;
      @(negedge core_clk);
      data_in = wd;
    end
    wr_n = ds ? !wr : !wr;
    rd_n = ds ? 1'b0 : wr;
    n = 0;
    while (transfer_ack_n !== 1'b0 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    check("ack low", 16'(transfer_ack_n), 16'h0);
    if (!wr) check("read lanes", 16'(data_oe), 16'(oe));
    if (!wr) check("read data", data_out & {{8{oe[1]}}, {8{oe[0]}}}, exp);
    if (wr) repeat (4) @(negedge core_clk);
    if (wr) check("ack held in write", 16'(transfer_ack_n), 16'h0);
    @(negedge core_clk);
    rd_n = 1'b1;
    wr_n = 1'b1;
    n = 0;
    while (transfer_ack_n !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    check("ack hold", 16'(n >= RDY_HOLD_CYC && n < 50), 16'h1);
    cs_n = 1'b1;
    data_in = ~data_in;
    @(negedge core_clk);
    check("idle lanes", 16'(data_oe), 16'h0);
  endtask

  initial begin
    {nrst, cs_n, rd_n, wr_n, ale, high_byte_enable_n, low_lane_enable_n} = 7'h3f;
    {bus_width_16, pll_locked, wait_cyc, host_mode_straps} = 8'h80;
    addr_in = 11'h0;
    data_in = 16'h0;
    for (int m = 3; m >= 2; m--) begin
      do_reset(2'(m), 16'ha9e0, 11'h02d);
      check("mode", 16'(host_mode), 16'(m));
      check("link en", 16'(serial_link_en), 16'(m == 3));
      check("spi en", 16'(spi_en), 16'(m == 2));
      check("src addr", 16'(link_src_addr), (m == 3) ? 16'h2d : 16'h0);
      check("mult m", 16'(clock_mult_cfg_a), 16'h15);
      check("mult n", 16'(clock_mult_cfg_b), 16'h0f);
      check("gate shut", 16'({serial_access_ok, serial_data_out_oe_allow}), 16'h0);
      pll_locked = 1'b1;
      polls = 0;
      while (!serial_access_ok && polls < 20) begin
        @(negedge core_clk);
        polls++;
      end
      check("lock polls", 16'(polls < 20), 16'h1);
      check("gate open", 16'({serial_access_ok, serial_data_out_oe_allow}),
            (m == 2) ? 16'h3 : 16'h2);
      host_mode_straps = 2'h0;
      repeat (4) @(negedge core_clk);
      check("mode kept", 16'(host_mode), 16'(m));
    end
    $display("test straps done");
    do_reset(2'h0, 16'ha9e0, 11'h02d);
    check("mode sep", 16'(host_mode), 16'h0);
    check("no strap mult", 16'({strap_mult_valid, clock_mult_cfg_a}), 16'h0);
    check("idle ack", 16'({transfer_ack_oe, transfer_ack_n, data_oe}), 16'hc);
    acc(0, 1, 0, 11'h010, 1'b0, 16'ha1b2, 16'h0, 2'h0);
    acc(0, 0, 0, 11'h011, 1'b0, 16'h0, 16'ha100, 2'h2);
    acc(0, 0, 0, 11'h010, 1'b1, 16'h0, 16'h00b2, 2'h1);
    acc(0, 1, 0, 11'h011, 1'b1, 16'hffff, 16'h0, 2'h0);
    wait_cyc = 4'h5;
    acc(0, 0, 0, 11'h010, 1'b0, 16'h0, 16'ha1b2, 2'h3);
    wait_cyc = 4'h0;
    bus_width_16 = 1'b0;
    acc(0, 1, 0, 11'h011, 1'b0, 16'h005c, 16'h0, 2'h0);
    acc(0, 0, 0, 11'h011, 1'b0, 16'h0, 16'h005c, 2'h1);
    bus_width_16 = 1'b1;
    acc(0, 0, 0, 11'h010, 1'b0, 16'h0, 16'h5cb2, 2'h3);
    acc(0, 1, 0, 11'h7fe, 1'b0, 16'h1357, 16'h0, 2'h0);
    acc(0, 0, 0, 11'h7fe, 1'b0, 16'h0, 16'h1357, 2'h3);
    check("wide addr", 16'(reg_addr), 16'h07fe);
    // once ale toggles the bus is multiplexed until the next reset
    acc(0, 1, 1, 11'h012, 1'b0, 16'h3c4d, 16'h0, 2'h0);
    acc(0, 0, 1, 11'h012, 1'b0, 16'h0, 16'h3c4d, 2'h3);
    $display("test separate strobe done");
    do_reset(2'h1, 16'h0, 11'h0);
    check("mode ds", 16'(host_mode), 16'h1);
    acc(1, 0, 0, 11'h010, 1'b0, 16'h0, 16'hb25c, 2'h3);
    acc(1, 0, 0, 11'h011, 1'b0, 16'h0, 16'h005c, 2'h1);
    acc(1, 0, 0, 11'h010, 1'b1, 16'h0, 16'hb200, 2'h2);
    acc(1, 1, 0, 11'h014, 1'b0, 16'h7788, 16'h0, 2'h0);
    acc(1, 0, 0, 11'h015, 1'b0, 16'h0, 16'h0088, 2'h1);
    bus_width_16 = 1'b0;
    acc(1, 0, 0, 11'h014, 1'b0, 16'h0, 16'h0077, 2'h1);
    bus_width_16 = 1'b1;
    $display("test data strobe done");
    test_done();
  end
endmodule // test_hip_top
